/* light_sensor_defs.vh */
`ifndef LIGHT_SENSOR_DEFS_VH
`define LIGHT_SENSOR_DEFS_VH

// Register offsets
`define ADDR_INTERRUPT_STATUS    8'h00
`define ADDR_MAIN_CONFIGURATION  8'h01
`define ADDR_RECEIVER_CONFIG     8'h02
`define ADDR_RESULT_HIGH_BYTE    8'h04
`define ADDR_RESULT_LOW_BYTE     8'h05
`define ADDR_UPPER_THRESH_HIGH   8'h06
`define ADDR_UPPER_THRESH_LOW    8'h07
`define ADDR_LOWER_THRESH_HIGH   8'h08
`define ADDR_LOWER_THRESH_LOW    8'h09
`define ADDR_PERSIST_TIMER       8'h0A
`define ADDR_GREEN_GAIN_TRIM     8'h0F
`define ADDR_INFRARED_GAIN_TRIM  8'h10

// Reset values
`define RST_INTERRUPT_STATUS     8'h04
`define RST_MAIN_CONFIGURATION   8'h24
`define RST_RECEIVER_CONFIG      8'h00
`define RST_THRESHOLD            14'h0000
`define RST_PERSIST_TIMER        2'h0
`define RST_GREEN_GAIN_TRIM      8'h80
`define RST_INFRARED_GAIN_TRIM   8'h80

// Field positions
`define STATUS_AMBIENT_BIT       0
`define STATUS_POWER_UP_BIT      2
`define MAIN_ENABLE_BIT          0
`define MAIN_MODE_LSB            2
`define MAIN_TRIM_SEL_BIT        5
`define MAIN_WRITE_MASK          8'h2D
`define RECV_TIME_LSB            2
`define RESULT_OVERFLOW_BIT      6

// Operating modes
`define MODE_SHUTDOWN            2'h0
`define MODE_GREEN_MINUS_IR      2'h1
`define MODE_GREEN_ONLY          2'h2
`define MODE_INFRARED_ONLY       2'h3

// Persist counts: consecutive out-of-window readings needed
`define PERSIST_COUNT_0          5'h01
`define PERSIST_COUNT_1          5'h04
`define PERSIST_COUNT_2          5'h08
`define PERSIST_COUNT_3          5'h10

// Target address, low bit from the address select pin (arbitrary value)
`define TARGET_ADDR_BASE         7'h4A

`define RESULT_FULL_MASK         14'h3FFF

`endif

/* sync_two_stage.v */
module sync_two_stage #(
    parameter W = 1
) (
    // Clock and reset
    input  wire         i_clk,
    input  wire         i_resetn,
    // Asynchronous levels
    input  wire [W-1:0] i_async,
    output wire [W-1:0] o_sync
);
    reg [W-1:0] meta_q;
    reg [W-1:0] sync_q;

    // Idle bus lines rest high
    always @(posedge i_clk) begin
        if (!i_resetn) begin
            meta_q <= {W{1'b1}};
            sync_q <= {W{1'b1}};
        end else begin
            meta_q <= i_async;
            sync_q <= meta_q;
        end
    end

    assign o_sync = sync_q;
endmodule // sync_two_stage

/* window_persist.v */
`include "light_sensor_defs.vh"

module window_persist (
    // Clock and reset
    input  wire        i_clk,
    input  wire        i_resetn,
    // Configuration
    input  wire        i_enable,
    input  wire [13:0] i_upper_limit,
    input  wire [13:0] i_lower_limit,
    input  wire [1:0]  i_persist_count_sel,
    // Readings
    input  wire        i_sample_valid,
    input  wire [13:0] i_sample,
    input  wire        i_overflow,
    // Event
    output wire        o_event
);
    reg [4:0] count_q;
    reg       event_q;
    reg [4:0] target;
    wire      outside;

    always @* begin
        case (i_persist_count_sel)
            2'h0:    target = `PERSIST_COUNT_0;
            2'h1:    target = `PERSIST_COUNT_1;
            2'h2:    target = `PERSIST_COUNT_2;
            default: target = `PERSIST_COUNT_3;
        endcase
    end

    assign outside = (i_sample > i_upper_limit) || (i_sample < i_lower_limit);

    always @(posedge i_clk) begin
        if (!i_resetn) begin
            count_q <= 5'h00;
            event_q <= 1'b0;
        end else begin
            event_q <= 1'b0;
            if (!i_enable) begin
                count_q <= 5'h00;
            end else if (i_sample_valid) begin
                if (i_overflow) begin
                    event_q <= 1'b1;
                end
                if (outside) begin
                    if (count_q + 5'h01 >= target) begin
                        event_q <= 1'b1;
                        count_q <= 5'h00;
                    end else begin
                        count_q <= count_q + 5'h01;
                    end
                end else begin
                    count_q <= 5'h00;
                end
            end
        end
    end

    assign o_event = event_q;
endmodule // window_persist

/* light_sensor_register_bank.v */
`include "light_sensor_defs.vh"

module light_sensor_register_bank (
    // Clock and reset
    input  wire        i_clk,
    input  wire        i_resetn,
    // Serial bus pins
    input  wire        i_scl,
    input  wire        i_sda,
    output wire        o_sda,
    output wire        o_sda_oe,
    input  wire        i_addr_sel,
    // Interrupt pin, open drain
    output wire        o_irq_n,
    output wire        o_irq_oe,
    // Converter readings
    input  wire        i_sample_valid,
    input  wire [13:0] i_sample,
    input  wire        i_sample_overflow,
    // Settings to the front end
    output wire [1:0]  o_mode,
    output wire        o_trim_sel,
    output wire [1:0]  o_integration_time_sel,
    output wire [1:0]  o_front_gain_sel,
    output wire [6:0]  o_green_fine_gain,
    output wire [8:0]  o_infrared_fine_gain
);
    localparam [3:0] ST_IDLE      = 4'h0;
    localparam [3:0] ST_ADDR      = 4'h1;
    localparam [3:0] ST_ADDR_ACK  = 4'h2;
    localparam [3:0] ST_PTR       = 4'h3;
    localparam [3:0] ST_PTR_ACK   = 4'h4;
    localparam [3:0] ST_WDATA     = 4'h5;
    localparam [3:0] ST_WDATA_ACK = 4'h6;
    localparam [3:0] ST_RDATA     = 4'h7;
    localparam [3:0] ST_RDATA_ACK = 4'h8;
    localparam [7:0] RECV_RST     = `RST_RECEIVER_CONFIG;
    localparam [6:0] ADDR_BASE    = `TARGET_ADDR_BASE;

    // Synchronised pins
    wire [2:0]  pins_sync;
    wire        scl_s;
    wire        sda_s;
    wire        a0_s;
    reg         scl_prev_q;
    reg         sda_prev_q;
    wire        scl_rise;
    wire        scl_fall;
    wire        start_cond;
    wire        stop_cond;

    // Protocol engine
    reg  [3:0]  state_q;
    reg  [3:0]  bit_cnt_q;
    reg  [7:0]  shift_q;
    reg  [7:0]  tx_q;
    reg  [7:0]  ptr_q;
    reg         sda_oe_q;
    reg         nack_q;
    reg         freeze_q;
    reg         wr_stb_q;
    reg  [7:0]  wr_addr_q;
    reg  [7:0]  wr_data_q;
    reg         rd_status_q;
    wire [6:0]  my_addr;

    // Register file
    reg         power_up_flag_q;
    reg         ambient_irq_flag_q;
    reg  [7:0]  main_cfg_q;
    reg  [1:0]  integration_time_sel_q;
    reg  [1:0]  front_gain_sel_q;
    reg  [13:0] upper_limit_q;
    reg  [13:0] lower_limit_q;
    reg  [1:0]  persist_count_sel_q;
    reg  [7:0]  green_trim_q;
    reg  [7:0]  infrared_trim_q;
    reg  [13:0] light_result_q;
    reg         overflow_flag_q;
    reg  [13:0] pend_result_q;
    reg         pend_overflow_q;
    reg         pend_valid_q;
    reg         irq_oe_q;
    reg  [7:0]  rd_byte;
    wire [13:0] res_mask;
    wire [13:0] masked_sample;
    wire        ambient_event;
    wire        ambient_irq_enable;
    wire        wr_main_enable_low;

    sync_two_stage #(
        .W (3)
    ) u_pin_sync (
        .i_clk    (i_clk),
        .i_resetn (i_resetn),
        .i_async  ({i_addr_sel, i_sda, i_scl}),
        .o_sync   (pins_sync)
    );

    assign scl_s = pins_sync[0];
    assign sda_s = pins_sync[1];
    assign a0_s  = pins_sync[2];

    always @(posedge i_clk) begin
        if (!i_resetn) begin
            scl_prev_q <= 1'b1;
            sda_prev_q <= 1'b1;
        end else begin
            scl_prev_q <= scl_s;
            sda_prev_q <= sda_s;
        end
    end

    assign scl_rise   = scl_s & ~scl_prev_q;
    assign scl_fall   = ~scl_s & scl_prev_q;
    assign start_cond = scl_s & scl_prev_q & sda_prev_q & ~sda_s;
    assign stop_cond  = scl_s & scl_prev_q & ~sda_prev_q & sda_s;
    assign my_addr    = {ADDR_BASE[6:1], a0_s};

    // Read data mux; unmapped offsets read zero
    always @* begin
        case (ptr_q)
            `ADDR_INTERRUPT_STATUS:
                rd_byte = {5'h00, power_up_flag_q, 1'b0, ambient_irq_flag_q};
            `ADDR_MAIN_CONFIGURATION: rd_byte = main_cfg_q;
            `ADDR_RECEIVER_CONFIG:
                rd_byte = {4'h0, integration_time_sel_q, front_gain_sel_q};
            `ADDR_RESULT_HIGH_BYTE:
                rd_byte = {1'b0, overflow_flag_q, light_result_q[13:8]};
            `ADDR_RESULT_LOW_BYTE:    rd_byte = light_result_q[7:0];
            `ADDR_UPPER_THRESH_HIGH:  rd_byte = {2'h0, upper_limit_q[13:8]};
            `ADDR_UPPER_THRESH_LOW:   rd_byte = upper_limit_q[7:0];
            `ADDR_LOWER_THRESH_HIGH:  rd_byte = {2'h0, lower_limit_q[13:8]};
            `ADDR_LOWER_THRESH_LOW:   rd_byte = lower_limit_q[7:0];
            `ADDR_PERSIST_TIMER:      rd_byte = {6'h00, persist_count_sel_q};
            `ADDR_GREEN_GAIN_TRIM:    rd_byte = green_trim_q;
            `ADDR_INFRARED_GAIN_TRIM: rd_byte = infrared_trim_q;
            default:                  rd_byte = 8'h00;
        endcase
    end

    // Serial protocol engine; shifts on SCL rise, drives on SCL fall
    always @(posedge i_clk) begin
        if (!i_resetn) begin
            state_q     <= ST_IDLE;
            bit_cnt_q   <= 4'h0;
            shift_q     <= 8'h00;
            tx_q        <= 8'h00;
            ptr_q       <= 8'h00;
            sda_oe_q    <= 1'b0;
            nack_q      <= 1'b0;
            freeze_q    <= 1'b0;
            wr_stb_q    <= 1'b0;
            wr_addr_q   <= 8'h00;
            wr_data_q   <= 8'h00;
            rd_status_q <= 1'b0;
        end else begin
            wr_stb_q    <= 1'b0;
            rd_status_q <= 1'b0;
            if (stop_cond) begin
                state_q  <= ST_IDLE;
                sda_oe_q <= 1'b0;
                freeze_q <= 1'b0;
            end else if (start_cond) begin
                state_q   <= ST_ADDR;
                bit_cnt_q <= 4'h0;
                sda_oe_q  <= 1'b0;
            end else if (scl_rise) begin
                case (state_q)
                    ST_ADDR, ST_PTR, ST_WDATA: begin
                        shift_q   <= {shift_q[6:0], sda_s};
                        bit_cnt_q <= bit_cnt_q + 4'h1;
                    end
                    ST_RDATA: bit_cnt_q <= bit_cnt_q + 4'h1;
                    ST_RDATA_ACK: nack_q <= sda_s;
                    default: ;
                endcase
            end else if (scl_fall) begin
                case (state_q)
                    ST_ADDR: begin
                        if (bit_cnt_q == 4'h8) begin
                            if (shift_q[7:1] == my_addr) begin
                                sda_oe_q <= 1'b1;
                                nack_q   <= 1'b0;
                                state_q  <= ST_ADDR_ACK;
                                if (shift_q[0]) begin
                                    freeze_q <= 1'b1;
                                end
                            end else begin
                                state_q <= ST_IDLE;
                            end
                        end
                    end
                    ST_ADDR_ACK, ST_RDATA_ACK: begin
                        bit_cnt_q <= 4'h0;
                        if (nack_q) begin
                            sda_oe_q <= 1'b0;
                            state_q  <= ST_IDLE;
                        end else if (state_q == ST_RDATA_ACK || shift_q[0]) begin
                            tx_q     <= rd_byte;
                            sda_oe_q <= ~rd_byte[7];
                            ptr_q    <= ptr_q + 8'h01;
                            state_q  <= ST_RDATA;
                            if (ptr_q == `ADDR_INTERRUPT_STATUS) begin
                                rd_status_q <= 1'b1;
                            end
                        end else begin
                            sda_oe_q <= 1'b0;
                            state_q  <= ST_PTR;
                        end
                    end
                    ST_PTR: begin
                        if (bit_cnt_q == 4'h8) begin
                            ptr_q    <= shift_q;
                            sda_oe_q <= 1'b1;
                            state_q  <= ST_PTR_ACK;
                        end
                    end
                    ST_WDATA: begin
                        if (bit_cnt_q == 4'h8) begin
                            wr_stb_q  <= 1'b1;
                            wr_addr_q <= ptr_q;
                            wr_data_q <= shift_q;
                            sda_oe_q  <= 1'b1;
                            state_q   <= ST_WDATA_ACK;
                        end
                    end
                    ST_PTR_ACK, ST_WDATA_ACK: begin
                        sda_oe_q  <= 1'b0;
                        bit_cnt_q <= 4'h0;
                        if (state_q == ST_WDATA_ACK) begin
                            ptr_q <= ptr_q + 8'h01;
                        end
                        state_q <= ST_WDATA;
                    end
                    ST_RDATA: begin
                        if (bit_cnt_q == 4'h8) begin
                            sda_oe_q <= 1'b0;
                            state_q  <= ST_RDATA_ACK;
                        end else begin
                            tx_q     <= {tx_q[6:0], 1'b0};
                            sda_oe_q <= ~tx_q[6];
                        end
                    end
                    default: ;
                endcase
            end
        end
    end

    assign ambient_irq_enable = main_cfg_q[`MAIN_ENABLE_BIT];
    assign wr_main_enable_low = wr_stb_q
        && (wr_addr_q == `ADDR_MAIN_CONFIGURATION)
        && !wr_data_q[`MAIN_ENABLE_BIT];

    // Host-writable registers
    always @(posedge i_clk) begin
        if (!i_resetn) begin
            main_cfg_q             <= `RST_MAIN_CONFIGURATION;
            integration_time_sel_q <= RECV_RST[3:2];
            front_gain_sel_q       <= RECV_RST[1:0];
            upper_limit_q          <= `RST_THRESHOLD;
            lower_limit_q          <= `RST_THRESHOLD;
            persist_count_sel_q    <= `RST_PERSIST_TIMER;
            green_trim_q           <= `RST_GREEN_GAIN_TRIM;
            infrared_trim_q        <= `RST_INFRARED_GAIN_TRIM;
        end else if (wr_stb_q) begin
            case (wr_addr_q)
                `ADDR_MAIN_CONFIGURATION:
                    main_cfg_q <= wr_data_q & `MAIN_WRITE_MASK;
                `ADDR_RECEIVER_CONFIG: begin
                    integration_time_sel_q <= wr_data_q[3:2];
                    front_gain_sel_q       <= wr_data_q[1:0];
                end
                `ADDR_UPPER_THRESH_HIGH: upper_limit_q[13:8] <= wr_data_q[5:0];
                `ADDR_UPPER_THRESH_LOW:  upper_limit_q[7:0]  <= wr_data_q;
                `ADDR_LOWER_THRESH_HIGH: lower_limit_q[13:8] <= wr_data_q[5:0];
                `ADDR_LOWER_THRESH_LOW:  lower_limit_q[7:0]  <= wr_data_q;
                `ADDR_PERSIST_TIMER: persist_count_sel_q <= wr_data_q[1:0];
                `ADDR_GREEN_GAIN_TRIM:    green_trim_q    <= wr_data_q;
                `ADDR_INFRARED_GAIN_TRIM: infrared_trim_q <= wr_data_q;
                default: ;
            endcase
        end
    end

    // Resolution follows integration time: 14, 12, 10 or 8 bits
    assign res_mask = `RESULT_FULL_MASK >> {integration_time_sel_q, 1'b0};
    assign masked_sample = i_sample & res_mask;

    // Readings held back while a read is open, applied after stop
    always @(posedge i_clk) begin
        if (!i_resetn) begin
            light_result_q  <= 14'h0000;
            overflow_flag_q <= 1'b0;
            pend_result_q   <= 14'h0000;
            pend_overflow_q <= 1'b0;
            pend_valid_q    <= 1'b0;
        end else if (freeze_q) begin
            if (i_sample_valid && o_mode != `MODE_SHUTDOWN) begin
                pend_result_q   <= masked_sample;
                pend_overflow_q <= i_sample_overflow;
                pend_valid_q    <= 1'b1;
            end
        end else if (i_sample_valid && o_mode != `MODE_SHUTDOWN) begin
            light_result_q  <= masked_sample;
            overflow_flag_q <= i_sample_overflow;
            pend_valid_q    <= 1'b0;
        end else if (pend_valid_q) begin
            light_result_q  <= pend_result_q;
            overflow_flag_q <= pend_overflow_q;
            pend_valid_q    <= 1'b0;
        end
    end

    window_persist u_window_persist (
        .i_clk               (i_clk),
        .i_resetn            (i_resetn),
        .i_enable            (ambient_irq_enable),
        .i_upper_limit       (upper_limit_q),
        .i_lower_limit       (lower_limit_q),
        .i_persist_count_sel (persist_count_sel_q),
        .i_sample_valid      (i_sample_valid && o_mode != `MODE_SHUTDOWN),
        .i_sample            (masked_sample),
        .i_overflow          (i_sample_overflow),
        .o_event             (ambient_event)
    );

    // Status flags; a new event beats a same-cycle read clear
    always @(posedge i_clk) begin
        if (!i_resetn) begin
            power_up_flag_q    <= 1'b1;
            ambient_irq_flag_q <= 1'b0;
            irq_oe_q           <= 1'b0;
        end else begin
            if (rd_status_q) begin
                power_up_flag_q <= 1'b0;
            end
            if (!ambient_irq_enable || wr_main_enable_low) begin
                ambient_irq_flag_q <= 1'b0;
            end else if (ambient_event) begin
                ambient_irq_flag_q <= 1'b1;
            end else if (rd_status_q) begin
                ambient_irq_flag_q <= 1'b0;
            end
            irq_oe_q <= power_up_flag_q | ambient_irq_flag_q;
        end
    end

    assign o_sda                  = 1'b0;
    assign o_sda_oe               = sda_oe_q;
    assign o_irq_n                = 1'b0;
    assign o_irq_oe               = irq_oe_q;
    assign o_mode                 = main_cfg_q[`MAIN_MODE_LSB+1:`MAIN_MODE_LSB];
    assign o_trim_sel             = main_cfg_q[`MAIN_TRIM_SEL_BIT];
    assign o_integration_time_sel = integration_time_sel_q;
    assign o_front_gain_sel       = front_gain_sel_q;
    assign o_green_fine_gain      = green_trim_q[7:1];
    assign o_infrared_fine_gain   = {infrared_trim_q, green_trim_q[0]};
endmodule // light_sensor_register_bank

/* light_sensor_props.sv */
module light_sensor_props (
    // Clock and reset
    input wire logic       i_clk,
    input wire logic       i_resetn,
    // Watched pins
    input wire logic       i_scl,
    input wire logic       i_sample_valid,
    input wire logic       o_sda_oe,
    input wire logic       o_irq_n,
    input wire logic       o_irq_oe,
    input wire logic [1:0] o_mode,
    input wire logic       o_trim_sel,
    input wire logic [1:0] o_integration_time_sel,
    input wire logic [1:0] o_front_gain_sel,
    input wire logic [6:0] o_green_fine_gain,
    input wire logic [8:0] o_infrared_fine_gain
);
    default clocking cb @(posedge i_clk); endclocking
    logic       scl_q;
    logic [5:0] quiet_q;
    // Cycles since the bus clock last moved
    always @(posedge i_clk) begin
        scl_q <= i_scl;
        if (!i_resetn || i_scl != scl_q)
            quiet_q <= 6'h00;
        else if (quiet_q != 6'h3F)
            quiet_q <= quiet_q + 6'h01;
    end
    sequence s_release;
        $rose(i_resetn);
    endsequence
    sequence s_irq_up;
        $rose(o_irq_oe) && $past(i_resetn, 4);
    endsequence
    a_reset_irq: assert property (s_release |-> ##[0:3] o_irq_oe)
        else $error("no power-up interrupt");
    a_reset_cfg: assert property (!i_resetn |=>
        o_mode == 2'h1 && o_trim_sel)
        else $error("main settings not at default");
    a_reset_trim: assert property (!i_resetn |=>
        o_green_fine_gain == 7'h40 && o_infrared_fine_gain == 9'h100 &&
        o_integration_time_sel == 2'h0 && o_front_gain_sel == 2'h0)
        else $error("front end settings not at default");
    a_irq_drive_low: assert property (o_irq_oe |-> o_irq_n == 1'b0)
        else $error("interrupt pin not low");
    a_cfg_on_bus: assert property (disable iff (!i_resetn)
        $past(i_resetn) && $changed(o_mode) |-> !i_scl)
        else $error("mode changed outside a bus write");
    a_irq_rise_cause: assert property (disable iff (!i_resetn)
        s_irq_up |-> $past(i_sample_valid, 2) || $past(i_sample_valid, 3))
        else $error("interrupt without a reading");
    a_irq_fall_cause: assert property (disable iff (!i_resetn)
        $fell(o_irq_oe) && $past(i_resetn) |-> quiet_q < 6'h10)
        else $error("interrupt cleared without bus access");
    a_sda_idle: assert property (disable iff (!i_resetn)
        quiet_q == 6'h3F |-> !o_sda_oe)
        else $error("data line held on idle bus");
endmodule // light_sensor_props

bind light_sensor_register_bank light_sensor_props u_props (
    .i_clk(i_clk), .i_resetn(i_resetn), .i_scl(i_scl),
    .i_sample_valid(i_sample_valid), .o_sda_oe(o_sda_oe),
    .o_irq_n(o_irq_n), .o_irq_oe(o_irq_oe), .o_mode(o_mode),
    .o_trim_sel(o_trim_sel), .o_front_gain_sel(o_front_gain_sel),
    .o_integration_time_sel(o_integration_time_sel),
    .o_green_fine_gain(o_green_fine_gain),
    .o_infrared_fine_gain(o_infrared_fine_gain)
);

/* i2c_host_model.sv */
module i2c_host_model (
    // Clock and bus pins
    input  wire logic i_clk,
    output logic      o_scl,
    output logic      o_sda_oe,
    input  wire logic i_sda
);
    timeunit 1ns;
    timeprecision 10ps;
    localparam real        Q   = 31.25;
    localparam logic [6:0] DEV = 7'h4B;
    initial o_scl = 1'b1;
    initial o_sda_oe = 1'b0;
    task automatic bit_io(input logic b, output logic r);
        #Q o_sda_oe = ~b;
        #Q o_scl = 1'b1;
        #Q r = i_sda;
        #Q o_scl = 1'b0;
    endtask
    task automatic start();
        #Q o_sda_oe = 1'b0;
        #Q o_scl = 1'b1;
        #Q o_sda_oe = 1'b1;
        #Q o_scl = 1'b0;
    endtask
    task automatic stop();
        #Q o_sda_oe = 1'b1;
        #Q o_scl = 1'b1;
        #Q o_sda_oe = 1'b0;
        #Q;
    endtask
    task automatic xfer(input logic [7:0] tx, input logic ai,
                        output logic [7:0] rx);
        logic a;
        for (int i = 7; i >= 0; i--)
            bit_io(tx[i], rx[i]);
        bit_io(ai, a);
    endtask
    task automatic wr(input logic [7:0] p, input logic [7:0] d);
        logic [7:0] r;
        @(negedge i_clk);
        #2 start();
        xfer({DEV, 1'b0}, 1'b1, r);
        xfer(p, 1'b1, r);
        xfer(d, 1'b1, r);
        stop();
    endtask
    task automatic rd(input logic [7:0] p, input int n,
                      output logic [15:0] v);
        logic [7:0] b;
        v = 16'h0000;
        @(negedge i_clk);
        #2 start();
        xfer({DEV, 1'b0}, 1'b1, b);
        xfer(p, 1'b1, b);
        start();
        xfer({DEV, 1'b1}, 1'b1, b);
        for (int i = 0; i < n; i++) begin
            xfer(8'hFF, i == n - 1, b);
            v = {v[7:0], b};
        end
        stop();
    endtask
endmodule // i2c_host_model

/* light_sensor_register_bank_tb_top.sv */
module light_sensor_register_bank_tb_top;
    timeunit 1ns;
    timeprecision 10ps;
    logic        i_clk = 1'b0;
    logic        i_resetn = 1'b0;
    logic        i_sample_valid = 1'b0;
    logic [13:0] i_sample = 14'h0000;
    logic        i_sample_overflow = 1'b0;
    logic        i_addr_sel = 1'b1;
    wire         scl, host_oe, dev_oe, irq_oe, trim_sel;
    wire  [1:0]  mode, itime, gain;
    wire  [6:0]  green;
    wire  [8:0]  infra;
    int          errors = 0;
    int          checks = 0;
    logic [15:0] v;
    logic [15:0] tbl [13] = '{16'h0000, 16'h0124, 16'h0200, 16'h0300,
        16'h0400, 16'h0500, 16'h0600, 16'h0700, 16'h0800, 16'h0900,
        16'h0A00, 16'h0F80, 16'h1080};
    // Open-drain data line with pull-up
    wire         sda = ~(host_oe | dev_oe);
    always #5 i_clk = ~i_clk;
    i2c_host_model u_host (.i_clk(i_clk), .o_scl(scl),
        .o_sda_oe(host_oe), .i_sda(sda));
    light_sensor_register_bank dut (.i_clk(i_clk), .i_resetn(i_resetn),
        .i_scl(scl), .i_sda(sda), .o_sda(), .o_sda_oe(dev_oe),
        .i_addr_sel(i_addr_sel), .o_irq_n(), .o_irq_oe(irq_oe),
        .i_sample_valid(i_sample_valid), .i_sample(i_sample),
        .i_sample_overflow(i_sample_overflow), .o_mode(mode),
        .o_trim_sel(trim_sel), .o_integration_time_sel(itime),
        .o_front_gain_sel(gain), .o_green_fine_gain(green),
        .o_infrared_fine_gain(infra));
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp) begin
            errors++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic smp(input logic [13:0] s, input logic ovf);
        @(negedge i_clk);
        i_sample_valid = 1'b1;
        i_sample = s;
        i_sample_overflow = ovf;
        @(negedge i_clk);
        i_sample_valid = 1'b0;
        repeat (4) @(negedge i_clk);
    endtask
    task automatic close_out();
        $display("checks=%0d errors=%0d", checks, errors);
        if (errors == 0 && checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    initial begin
        #400_000;
        errors++;
        close_out();
    end
    initial begin
        repeat (6) @(negedge i_clk);
        i_resetn = 1'b1;
        repeat (5) @(negedge i_clk);
        chk(16'(irq_oe), 16'h0001);
        chk(16'({mode, trim_sel}), 16'h0003);
        chk({green, infra}, 16'h8100);
        u_host.rd(8'h00, 1, v);
        chk(v, 16'h0004);
        chk(16'(irq_oe), 16'h0000);
        foreach (tbl[i]) begin
            u_host.rd(tbl[i][15:8], 1, v);
            chk(v, {8'h00, tbl[i][7:0]});
        end
        $display("reset test done");
        for (int m = 0; m < 4; m++) begin
            u_host.wr(8'h01, 8'(m << 2));
            chk(16'(mode), 16'(m));
        end
        u_host.wr(8'h01, 8'hFF);
        u_host.rd(8'h01, 1, v);
        chk(v, 16'h002D);
        u_host.wr(8'h02, 8'h0F);
        u_host.rd(8'h02, 1, v);
        chk({v[7:0], 4'h0, itime, gain}, 16'h0F0F);
        u_host.wr(8'h0F, 8'h55);
        u_host.wr(8'h10, 8'hAA);
        chk({green, infra}, {7'h2A, 9'h155});
        u_host.wr(8'h02, 8'h00);
        u_host.wr(8'h01, 8'h04);
        $display("config test done");
        smp(14'h0020, 1'b0);
        chk(16'(irq_oe), 16'h0000);
        u_host.rd(8'h00, 1, v);
        chk(v, 16'h0000);
        u_host.wr(8'h01, 8'h05);
        smp(14'h0020, 1'b0);
        chk(16'(irq_oe), 16'h0001);
        u_host.rd(8'h00, 1, v);
        chk({v[7:0], 7'h00, irq_oe}, 16'h0100);
        smp(14'h0020, 1'b0);
        repeat (50) @(negedge i_clk);
        chk(16'(irq_oe), 16'h0001);
        u_host.wr(8'h01, 8'h04);
        u_host.rd(8'h00, 1, v);
        chk({v[7:0], 7'h00, irq_oe}, 16'h0000);
        // Persist select 1: four readings outside the window
        u_host.wr(8'h0A, 8'h01);
        u_host.wr(8'h01, 8'h05);
        repeat (3) smp(14'h0020, 1'b0);
        chk(16'(irq_oe), 16'h0000);
        smp(14'h0020, 1'b0);
        u_host.rd(8'h00, 1, v);
        chk(v, 16'h0001);
        u_host.wr(8'h0A, 8'h00);
        $display("ambient test done");
        u_host.wr(8'h06, 8'h3F);
        u_host.wr(8'h07, 8'hFF);
        u_host.wr(8'h01, 8'h05);
        smp(14'h0005, 1'b1);
        u_host.rd(8'h00, 1, v);
        chk(v, 16'h0001);
        u_host.rd(8'h04, 2, v);
        chk(v, 16'h4005);
        smp(14'h1234, 1'b0);
        chk(16'(irq_oe), 16'h0000);
        // New reading lands while the pair is being read
        fork
            u_host.rd(8'h04, 2, v);
            #4000 smp(14'h0ABC, 1'b0);
        join
        chk(v, 16'h1234);
        u_host.rd(8'h04, 2, v);
        chk(v, 16'h0ABC);
        u_host.wr(8'h02, 8'h0C);
        smp(14'h1234, 1'b0);
        u_host.rd(8'h04, 2, v);
        chk(v, 16'h0034);
        // Shutdown keeps the last result
        u_host.wr(8'h01, 8'h00);
        smp(14'h0001, 1'b0);
        u_host.rd(8'h04, 2, v);
        chk(v, 16'h0034);
        $display("result test done");
        @(negedge i_clk);
        i_resetn = 1'b0;
        repeat (6) @(negedge i_clk);
        i_resetn = 1'b1;
        repeat (5) @(negedge i_clk);
        u_host.rd(8'h06, 2, v);
        chk(v, 16'h0000);
        u_host.rd(8'h00, 1, v);
        chk(v, 16'h0004);
        $display("second reset test done");
        close_out();
    end
endmodule // light_sensor_register_bank_tb_top
